// ### src/dac_serial_front_end.sv
// serial write front end of a single-channel converter with apb view
// assumes link pins are asynchronous to clock and far slower than it
// Functional notes
// RULE1: each write is a 24-bit word on select, serial clock and data.
// RULE2: reset clears the output code to zero scale.
// RULE3: output code is straight binary of 16, 14 or 12 bits.
// RULE4: gain is unity after reset, doubles when gain bit written.
// RULE5: reference enabled at reset, disabled by control bit 16.
// RULE6: while select low, data is shifted in on serial clock fall.
// RULE7: host keeps select low until all 24 bits are clocked.
// RULE8: captured word is decoded when select rises.
// RULE9: host keeps select high at least 20 ns between words.
// RULE10: frame of 24 falling edges is valid, first 24 bits used.
// RULE11: 12-bit variant accepts 16 to 23 edges, decodes first 16.
// RULE12: 12-bit variant discards frames under 16 edges.
// RULE13: short frames are not accepted while chain mode is on.
// RULE14: serial out changes on rising clock, active in chain or readback.
// RULE15: inactive serial out is a weak low others may override.
// RULE16: serial out disabled after reset until chain bit is set; here a readback command also enables it.
// RULE17: chain mode accepts longer frames, decoding the last 24 bits.
// RULE18: shift register is 24 bits, msb first, top four bits command.
// RULE19: 20-bit data field holds the code left aligned.
// RULE20: buffer register reaches output only on a transfer request.
// RULE21: output code loads by direct write or copy from buffer.
// RULE22: commands: nop, write buffer, transfer, write both, control, readback.
// RULE23: direct output write also copies the value into the buffer.
// RULE24: readback clears the chain enable bit.
// RULE25: soft reset bit clears codes and control, then clears itself.
// RULE26: without short write, frames under 24 edges are discarded.
// RULE27: counter and shift register restart when select falls.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
module dac_serial_front_end
  import dac_front_pkg::*;
#(
  parameter int CODE_BITS = 16,
  parameter bit SHORT_WRITE = (CODE_BITS == 12)
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frameSel_n,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic loadStrobe_n,
  output logic serialOut,
  output logic serialOutOe,
  output logic serialOutWeakLow,
  output logic [CODE_BITS-1:0] outputCode,
  output logic gainTwo,
  output logic refEnable,
  output logic powerdownSelHi,
  output logic powerdownSelLo,
  output logic chainEnable
);
  import dac_front_pkg::*;

  logic [3:0] pinSync;
  logic frameNow;
  logic sclkNow;
  logic dataNow;
  logic strobeNow;
  logic framePrev;
  logic sclkPrev;
  logic strobePrev;
  logic [WORD_BITS-1:0] shiftReg;
  logic [WORD_BITS-1:0] readShift;
  logic [COUNT_BITS-1:0] bitCount;
  logic [CODE_BITS-1:0] bufferCode;
  logic refDisable;
  logic readbackActive;
  logic [1:0] strobeConfig;
  logic [15:0] acceptCount;
  logic [15:0] rejectCount;

  sync_bits #(
    .WIDTH(4),
    .IDLE(PIN_IDLE)
  ) pinSyncInst (
    .clock(clock),
    .resetn(resetn),
    .async({loadStrobe_n, serialIn, serialClk, frameSel_n}),
    .synced(pinSync)
  );

  assign frameNow = pinSync[0];
  assign sclkNow = pinSync[1];
  assign dataNow = pinSync[2];
  assign strobeNow = pinSync[3];

  // edge detection on the synchronised pins
  wire frameStart = framePrev && !frameNow;
  wire frameEnd = !framePrev && frameNow;
  wire inFrame = !frameNow;
  wire sclkFall = sclkPrev && !sclkNow && inFrame;
  wire sclkRise = !sclkPrev && sclkNow && inFrame;
  wire strobeFall = strobePrev && !strobeNow;

  // frame qualification
  wire fullFrame = (bitCount >= COUNT_FULL); // RULE10
  wire shortFrame = SHORT_WRITE && !chainEnable && // RULE13
    (bitCount >= COUNT_SHORT) && (bitCount < COUNT_FULL); // RULE11
  // anything else is dropped // RULE12 RULE26
  wire frameValid = fullFrame || shortFrame;
  // a short frame is left aligned first, so its first 16 bits win
  wire [COUNT_BITS-1:0] shortShift = COUNT_FULL - bitCount;
  wire [WORD_BITS-1:0] shortAligned = shiftReg << shortShift;
  wire [WORD_BITS-1:0] word = shortFrame ?
    {shortAligned[WORD_BITS-1 -: SHORT_BITS], 8'h00} : shiftReg; // RULE11
  wire execute = frameEnd && frameValid; // RULE8

  // word fields
  wire [3:0] cmd = word[CMD_MSB:CMD_LSB]; // RULE18
  wire [CODE_BITS-1:0] wordCode =
    word[DATA_MSB -: CODE_BITS]; // RULE19 RULE3
  wire isWriteBuffer = execute && (cmd == CMD_WRITE_BUFFER); // RULE22
  wire isTransfer = execute && (cmd == CMD_TRANSFER);
  wire isWriteBoth = execute && (cmd == CMD_WRITE_BOTH);
  wire isControl = execute && (cmd == CMD_WRITE_CONTROL);
  wire isReadback = execute && (cmd == CMD_READBACK);
  wire softReset = isControl && word[SOFT_RESET_POSITION]; // RULE25

  // hardware transfer, maskable from software
  wire hwTransfer = strobeFall && !strobeConfig[CONFIG_HOLD_STROBE]; // RULE20

  // chain mode keeps shifting so the last 24 bits survive
  wire shiftEnable = sclkFall &&
    (chainEnable || (bitCount < COUNT_FULL)); // RULE17 RULE10

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      framePrev <= 1'b1;
      sclkPrev <= 1'b1;
      strobePrev <= 1'b1;
    end
    else
    begin
      framePrev <= frameNow;
      sclkPrev <= sclkNow;
      strobePrev <= strobeNow;
    end
  end

  // input shift register and bit counter
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      shiftReg <= SHIFT_RESET;
      bitCount <= '0;
    end
    else if (frameStart)
    begin
      shiftReg <= SHIFT_RESET; // RULE27
      bitCount <= '0;
    end
    else if (sclkFall)
    begin
      if (shiftEnable)
      begin
        shiftReg <= {shiftReg[WORD_BITS-2:0], dataNow}; // RULE6 RULE18
      end
      if (bitCount < COUNT_FULL)
      begin
        bitCount <= bitCount + 1'b1; // RULE1
      end
    end
  end

  // code registers
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      outputCode <= CODE_RESET[CODE_BITS-1:0]; // RULE2
      bufferCode <= CODE_RESET[CODE_BITS-1:0];
    end
    else if (softReset)
    begin
      outputCode <= CODE_RESET[CODE_BITS-1:0]; // RULE25
      bufferCode <= CODE_RESET[CODE_BITS-1:0];
    end
    else if (isWriteBoth)
    begin
      outputCode <= wordCode; // RULE21
      bufferCode <= wordCode; // RULE23
    end
    else
    begin
      if (isWriteBuffer)
      begin
        bufferCode <= wordCode; // RULE20
      end
      if (isTransfer || hwTransfer)
      begin
        outputCode <= bufferCode; // RULE21
      end
    end
  end

  // control register; the soft reset bit is never stored
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      gainTwo <= GAIN_RESET; // RULE4
      refDisable <= REF_DISABLE_RESET; // RULE5
      {powerdownSelHi, powerdownSelLo} <= POWERDOWN_RESET;
      chainEnable <= CHAIN_RESET; // RULE16
    end
    else if (softReset)
    begin
      gainTwo <= GAIN_RESET; // RULE25
      refDisable <= REF_DISABLE_RESET;
      {powerdownSelHi, powerdownSelLo} <= POWERDOWN_RESET;
      chainEnable <= CHAIN_RESET;
    end
    else if (isControl)
    begin
      gainTwo <= word[GAIN_POSITION]; // RULE4
      refDisable <= word[REF_CONTROL_POSITION]; // RULE5
      powerdownSelHi <= word[POWERDOWN_HI_POSITION];
      powerdownSelLo <= word[POWERDOWN_LO_POSITION];
      chainEnable <= word[CHAIN_CONTROL_POSITION]; // RULE16
    end
    else if (isReadback)
    begin
      chainEnable <= 1'b0; // RULE24
    end
  end

  assign refEnable = !refDisable; // RULE5

  // readback runs for the frame after the readback command
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      readbackActive <= 1'b0;
    end
    else if (isReadback)
    begin
      readbackActive <= 1'b1;
    end
    else if (frameEnd || softReset)
    begin
      readbackActive <= 1'b0;
    end
  end

  // serial out: driven only when active, weak low otherwise
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      readShift <= SHIFT_RESET;
      serialOut <= 1'b0;
    end
    else if (frameStart && readbackActive)
    begin
      readShift <= SHIFT_RESET;
      readShift[DATA_MSB -: CODE_BITS] <= bufferCode;
    end
    else if (sclkRise && readbackActive)
    begin
      serialOut <= readShift[WORD_BITS-1]; // RULE14
      readShift <= {readShift[WORD_BITS-2:0], 1'b0};
    end
    else if (sclkRise && chainEnable)
    begin
      serialOut <= shiftReg[WORD_BITS-1]; // RULE14 RULE17
    end
    else if (!(chainEnable || readbackActive))
    begin
      serialOut <= 1'b0; // RULE15
    end
  end

  assign serialOutOe = chainEnable || readbackActive; // RULE14 RULE16
  assign serialOutWeakLow = !serialOutOe; // RULE15

  // frame statistics for software, wrap on overflow
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      acceptCount <= '0;
      rejectCount <= '0;
    end
    else if (frameEnd)
    begin
      if (frameValid)
      begin
        acceptCount <= acceptCount + 1'b1;
      end
      else
      begin
        rejectCount <= rejectCount + 1'b1;
      end
    end
  end

  // apb slave: zero wait states, error on unmapped addresses
  wire apbAccess = psel && penable;
  wire hitStatus = (paddr == ADDR_STATUS);
  wire hitCode = (paddr == ADDR_CODE);
  wire hitBuffer = (paddr == ADDR_BUFFER);
  wire hitConfig = (paddr == ADDR_CONFIG);
  wire hitFrames = (paddr == ADDR_FRAMES);
  wire mapped = hitStatus || hitCode || hitBuffer || hitConfig || hitFrames;
  wire configWrite = apbAccess && pwrite && hitConfig;

  wire [31:0] statusWord = {19'h00000, bitCount, readbackActive,
    chainEnable, gainTwo, refDisable, powerdownSelHi, powerdownSelLo,
    !frameNow, 1'b0};
  wire [31:0] codeWord = {{(32-CODE_BITS){1'b0}}, outputCode};
  wire [31:0] bufferWord = {{(32-CODE_BITS){1'b0}}, bufferCode};
  wire [31:0] configWord = {30'h00000000, strobeConfig};
  wire [31:0] framesWord = {rejectCount, acceptCount};
  wire [31:0] readMux = hitStatus ? statusWord :
    hitCode ? codeWord :
    hitBuffer ? bufferWord :
    hitConfig ? configWord :
    hitFrames ? framesWord : 32'h00000000;

  assign pready = 1'b1;
  assign pslverr = apbAccess && !mapped;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      strobeConfig <= CONFIG_RESET;
    end
    else if (configWrite)
    begin
      strobeConfig <= pwdata[1:0];
    end
  end

  // read data registered in the setup cycle, stable through access
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata <= 32'h00000000;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata <= readMux;
    end
  end
endmodule // dac_serial_front_end

// ### include/dac_front_pkg.sv
// constants shared by the serial write front end and its apb view
// assumes a 32-bit apb bus and a 24-bit serial command word
package dac_front_pkg;
  localparam int WORD_BITS = 24;
  localparam int SHORT_BITS = 16;
  localparam int COUNT_BITS = 5;
  localparam logic [COUNT_BITS-1:0] COUNT_FULL = 5'h18;
  localparam logic [COUNT_BITS-1:0] COUNT_SHORT = 5'h10;
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 20;
  localparam int DATA_MSB = 19;
  // control word bit positions inside the 24-bit word
  localparam int SOFT_RESET_POSITION = 19;
  localparam int POWERDOWN_HI_POSITION = 18;
  localparam int POWERDOWN_LO_POSITION = 17;
  localparam int REF_CONTROL_POSITION = 16;
  localparam int GAIN_POSITION = 15;
  localparam int CHAIN_CONTROL_POSITION = 14;
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_WRITE_BUFFER = 4'h1,
    CMD_TRANSFER = 4'h2,
    CMD_WRITE_BOTH = 4'h3,
    CMD_WRITE_CONTROL = 4'h4,
    CMD_READBACK = 4'h5
  } command_t;
  // apb map
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CODE = 8'h04;
  localparam logic [7:0] ADDR_BUFFER = 8'h08;
  localparam logic [7:0] ADDR_CONFIG = 8'h0C;
  localparam logic [7:0] ADDR_FRAMES = 8'h10;
  localparam int CONFIG_HOLD_STROBE = 0;
  localparam logic [1:0] CONFIG_RESET = 2'h0;
  // control defaults: unity gain, reference on, normal mode, chain off
  localparam logic GAIN_RESET = 1'b0;
  localparam logic REF_DISABLE_RESET = 1'b0;
  localparam logic [1:0] POWERDOWN_RESET = 2'h0;
  localparam logic CHAIN_RESET = 1'b0;
  localparam logic [WORD_BITS-1:0] SHIFT_RESET = 24'h000000;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  // idle levels of the link pins: select and strobe idle high
  localparam logic [3:0] PIN_IDLE = 4'hB;
endpackage

// ### src/sync_bits.sv
// two-stage synchroniser for a group of independent level inputs
// assumes each bit is a slow level relative to clock
`timescale 1ns/1ns
module sync_bits
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stage1;

  // stage1 feeds nothing but the second flop
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1 <= IDLE;
      synced <= IDLE;
    end
    else
    begin
      stage1 <= async;
      synced <= stage1;
    end
  end
endmodule // sync_bits

// ### verif/dac_serial_front_end_checker.sv
// port assertions for the serial write front end
// assumes link pins idle high and are seen only as sampled levels
`timescale 1ns/1ns
module dac_serial_front_end_checker
#(
  parameter int CODE_BITS = 16
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frameSel_n,
  input wire logic serialClk,
  input wire logic loadStrobe_n,
  input wire logic serialOut,
  input wire logic serialOutOe,
  input wire logic serialOutWeakLow,
  input wire logic [CODE_BITS-1:0] outputCode,
  input wire logic gainTwo,
  input wire logic refEnable,
  input wire logic chainEnable
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  chk_weak_low: assert property (serialOutWeakLow == !serialOutOe)
    else $error("weak low not inverse of enable");
  chk_idle_out: assert property (!serialOutOe |-> !serialOut)
    else $error("serial out high while idle");
  chk_chain_drives: assert property (chainEnable |-> serialOutOe)
    else $error("chain mode without output enable");
  // the output follows a sampled rise, so the pin is still high then
  chk_out_rise: assert property (
    serialOutOe && $changed(serialOut) |-> serialClk)
    else $error("serial out moved outside clock high");
  chk_reset_state: assert property ($rose(resetn) |->
    outputCode == '0 && !gainTwo && refEnable && !chainEnable && !serialOutOe)
    else $error("wrong state after reset");
  chk_frame_quiet: assert property (
    (!frameSel_n && loadStrobe_n) [*6] |-> $stable(outputCode))
    else $error("code moved inside a frame");
  chk_idle_quiet: assert property (
    (frameSel_n && loadStrobe_n) [*8] |-> $stable(outputCode))
    else $error("code moved between frames");
  cover property ($changed(outputCode));
  cover property ($rose(chainEnable));
  cover property ($fell(serialOutOe));
endmodule // dac_serial_front_end_checker

bind dac_serial_front_end dac_serial_front_end_checker
  #(.CODE_BITS(CODE_BITS)) checker_inst
(
  .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .frameSel_n(frameSel_n),
  .serialClk(serialClk), .loadStrobe_n(loadStrobe_n),
  .serialOut(serialOut), .serialOutOe(serialOutOe),
  .serialOutWeakLow(serialOutWeakLow), .outputCode(outputCode),
  .gainTwo(gainTwo), .refEnable(refEnable), .chainEnable(chainEnable)
);

// ### verif/serial_host_model.sv
// host side of the serial write link, with readback capture
// assumes the caller spaces frames; clock stands high between frames
`timescale 1ns/1ns
module serial_host_model
(
  output logic frameSel_n,
  output logic serialClk,
  output logic serialIn,
  input wire logic serialLine
);
  logic [23:0] rx;
  initial
  begin
    frameSel_n = 1'b1;
    serialClk = 1'b1;
    serialIn = 1'b0;
    rx = 24'h000000;
  end
  // bit n-1 goes first; data held from rise to rise around each fall
  task automatic send(input logic [31:0] w, input int n);
    frameSel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serialIn = w[i];
      #62 serialClk = 1'b0;
      #50 rx = {rx[22:0], serialLine};
      #13 serialClk = 1'b1;
    end
    #50 rx = {rx[22:0], serialLine};
    #12 frameSel_n = 1'b1;
    // released data must not look like a held last bit
    serialIn = ~serialIn;
    #100;
  endtask
endmodule // serial_host_model

// ### verif/dac_serial_front_end_test.sv
// self-checking bench: apb master tasks plus serial host model
// assumes a 16-bit variant on apb and a 12-bit one sharing the link pins
`timescale 1ns/1ns
module dac_serial_front_end_test;
  import dac_front_pkg::*;
  logic clock, resetn, psel, penable, pwrite, loadStrobe_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic pready, pslverr, e, frameSel_n, serialClk, serialIn, serialLine;
  logic serialOut, serialOutOe, serialOutWeakLow;
  logic gainTwo, refEnable, powerdownSelHi, powerdownSelLo, chainEnable;
  logic [15:0] outputCode;
  logic [11:0] code12;
  int numErrors = 0;
  int numChecks = 0;
  // the weak pull-down wins whenever the output is not driven
  assign serialLine = serialOutOe ? serialOut : 1'b0;
  dac_serial_front_end dut (.clock(clock), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frameSel_n(frameSel_n), .serialClk(serialClk), .serialIn(serialIn),
    .loadStrobe_n(loadStrobe_n), .serialOut(serialOut),
    .serialOutOe(serialOutOe), .serialOutWeakLow(serialOutWeakLow),
    .outputCode(outputCode), .gainTwo(gainTwo), .refEnable(refEnable),
    .powerdownSelHi(powerdownSelHi), .powerdownSelLo(powerdownSelLo),
    .chainEnable(chainEnable));
  serial_host_model host (.frameSel_n(frameSel_n), .serialClk(serialClk),
    .serialIn(serialIn), .serialLine(serialLine));
  // short-write variant listens to the same frames; no bus of its own
  dac_serial_front_end #(.CODE_BITS(12)) dut12 (.clock(clock),
    .resetn(resetn), .psel(1'b0), .penable(1'b0), .pwrite(1'b0),
    .paddr(8'h00), .pwdata(32'h00000000), .prdata(), .pready(),
    .pslverr(), .frameSel_n(frameSel_n), .serialClk(serialClk),
    .serialIn(serialIn), .loadStrobe_n(loadStrobe_n), .serialOut(),
    .serialOutOe(), .serialOutWeakLow(), .outputCode(code12),
    .gainTwo(), .refEnable(), .powerdownSelHi(), .powerdownSelLo(),
    .chainEnable());
  task automatic chk(input string nm, input logic [31:0] got,
    input logic [31:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      numErrors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input logic [31:0] w, input int n);
    host.send(w, n);
    repeat (6) @(posedge clock);
  endtask
  task automatic strobe();
    @(posedge clock);
    loadStrobe_n <= 1'b0;
    repeat (4) @(posedge clock);
    loadStrobe_n <= 1'b1;
    repeat (6) @(posedge clock);
  endtask
  task automatic reportAndStop();
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial
  begin
    #300000;
    numErrors++;
    reportAndStop();
  end
  initial
  begin
    resetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    loadStrobe_n = 1'b1;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    chk("code", outputCode, 32'h00000000);
    chk("gain", gainTwo, 32'h00000000);
    chk("ref", refEnable, 32'h00000001);
    chk("oe", serialOutOe, 32'h00000000);
    $display("test reset done");
    frame({8'h00, CMD_WRITE_BOTH, 16'hABCD, 4'h0}, 24);
    chk("code", outputCode, 32'h0000ABCD);
    chk("code12", code12, 32'h00000ABC);
    apb(1'b0, ADDR_BUFFER, 32'h0, d, e);
    chk("buffer", d, 32'h0000ABCD);
    frame({8'h00, CMD_WRITE_BUFFER, 16'h1234, 4'h0}, 24);
    chk("code", outputCode, 32'h0000ABCD);
    frame({8'h00, CMD_TRANSFER, 20'h00000}, 24);
    chk("code", outputCode, 32'h00001234);
    frame({12'h000, CMD_WRITE_BOTH, 16'h9999}, 20);
    chk("code", outputCode, 32'h00001234);
    chk("code12", code12, 32'h00000999);
    apb(1'b0, ADDR_FRAMES, 32'h0, d, e);
    chk("rejects", d >> 16, 32'h00000001);
    frame({20'h00000, CMD_WRITE_BOTH, 8'hFF}, 12);
    chk("code", outputCode, 32'h00001234);
    chk("code12", code12, 32'h00000999);
    $display("test frames done");
    frame({8'h00, CMD_WRITE_BUFFER, 16'h5555, 4'h0}, 24);
    strobe();
    chk("code", outputCode, 32'h00005555);
    apb(1'b1, ADDR_CONFIG, 32'h00000001, d, e);
    frame({8'h00, CMD_WRITE_BUFFER, 16'h7777, 4'h0}, 24);
    strobe();
    chk("code", outputCode, 32'h00005555);
    apb(1'b1, ADDR_CONFIG, 32'h00000000, d, e);
    apb(1'b0, 8'h20, 32'h0, d, e);
    chk("unmapped err", e, 32'h00000001);
    chk("unmapped data", d, 32'h00000000);
    $display("test strobe done");
    frame({8'h00, CMD_WRITE_CONTROL, 20'h5C000}, 24);
    chk("pd", {powerdownSelHi, powerdownSelLo}, 32'h00000002);
    chk("gain", gainTwo, 32'h00000001);
    chk("ref", refEnable, 32'h00000000);
    chk("chain", chainEnable, 32'h00000001);
    chk("oe", serialOutOe, 32'h00000001);
    frame({8'hA5, CMD_WRITE_BOTH, 16'h0042, 4'h0}, 32);
    chk("code", outputCode, 32'h00000042);
    frame({12'h000, CMD_WRITE_BOTH, 16'h8888}, 20);
    chk("code", outputCode, 32'h00000042);
    chk("code12", code12, 32'h00000004);
    frame({8'h00, CMD_READBACK, 20'h00000}, 24);
    chk("chain", chainEnable, 32'h00000000);
    frame({8'h00, CMD_NOP, 20'h00000}, 24);
    chk("readback", host.rx, {8'h00, 4'h0, 16'h0042, 4'h0});
    chk("oe", serialOutOe, 32'h00000000);
    $display("test chain done");
    frame({8'h00, CMD_WRITE_CONTROL, 20'h80000}, 24);
    chk("code", outputCode, 32'h00000000);
    chk("gain", gainTwo, 32'h00000000);
    chk("ref", refEnable, 32'h00000001);
    chk("pd", {powerdownSelHi, powerdownSelLo}, 32'h00000000);
    chk("code12", code12, 32'h00000000);
    apb(1'b0, ADDR_BUFFER, 32'h0, d, e);
    chk("buffer", d, 32'h00000000);
    $display("test soft reset done");
    reportAndStop();
  end
endmodule // dac_serial_front_end_test
